// File: hvm_route_ctrl.sv
`timescale 1ns/1ps
module hvm_route_ctrl
  import hvm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // mode state from the mode machine
  input wire logic [2:0] mode,
  input wire logic sleep_cmd,
  input wire logic other_wake_src,
  // configuration writes
  input wire logic meas_wr,
  input wire logic meas_wdata,
  input wire logic gpio_wr,
  input wire logic [2:0] gpio_wdata,
  input wire logic pull_wr,
  input wire logic [1:0] pull_wdata,
  input wire logic wake2_wr,
  input wire logic [1:0] wake2_wdata,
  input wire logic wake_en_wr,
  input wire logic wake_en_wdata,
  input wire logic fail_output_test_drive,
  // raw pin-side events from the front ends
  input wire logic sense_wake_evt,
  input wire logic gpio_wake_evt,
  input wire logic sense_level,
  // outputs
  output logic measure_path_enable,
  output logic measure_route_switch,
  output logic [2:0] gpio_config,
  output logic [1:0] sense_pull_config,
  output logic [1:0] wake_control_second,
  output logic sense_wake_enable,
  output logic [1:0] pull_active,
  output logic fail_out_active,
  output logic gpio_func_active,
  output logic sense_wake_set,
  output logic gpio_wake_set,
  output logic level_update,
  output logic level_value,
  output logic spi_fault,
  output logic restart_req
);
  typedef struct packed {
    logic meas;
    logic sw;
    logic [2:0] gpio;
    logic [1:0] pull;
    logic [1:0] wake2;
    logic wken;
    logic [1:0] pact;
    logic fo;
    logic gact;
    logic swk;
    logic gwk;
    logic lvu;
    logic lvv;
    logic fault;
    logic rst;
    logic [1:0] swsync;
    logic [1:0] gwsync;
    logic [1:0] lvsync;
  } hvm_state_s;

  hvm_state_s st;
  hvm_state_s next_st;

  // ---------------------------------------------------
  // next state
  // ---------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.fault = 1'b0;
    next_st.rst = 1'b0;
    // pin levels are asynchronous: stage one feeds stage two only,
    // so a metastable first stage never reaches the logic
    next_st.swsync = {st.swsync[0], sense_wake_evt};
    next_st.gwsync = {st.gwsync[0], gpio_wake_evt};
    next_st.lvsync = {st.lvsync[0], sense_level};
    // settings are always stored, even while measuring
    if (pull_wr) begin
      next_st.pull = pull_wdata;
    end
    if (wake2_wr) begin
      next_st.wake2 = wake2_wdata;
    end
    if (wake_en_wr) begin
      next_st.wken = wake_en_wdata;
    end
    if (gpio_wr) begin
      next_st.gpio = gpio_wdata;
      if (st.meas && gpio_wdata != st.gpio) begin
        next_st.fault = 1'b1;
      end
    end
    if (meas_wr) begin
      if (meas_wdata && st.gpio != HVM_GPIO_OFF) begin
        next_st.fault = 1'b1;
      end else begin
        next_st.meas = meas_wdata;
      end
    end
    // sleep with only pin wake sources cannot leave sleep again
    if (sleep_cmd && st.meas && !other_wake_src) begin
      next_st.fault = 1'b1;
      next_st.rst = 1'b1;
    end
    // mode leaving normal opens switch, setting kept
    next_st.sw = next_st.meas && (mode == HVM_MODE_NORMAL);
    next_st.pact = next_st.meas ? 2'h0 : next_st.pull;
    next_st.fo = !next_st.meas && !fail_output_test_drive ? 1'b0 :
                 !next_st.meas;
    next_st.gact = !next_st.meas && next_st.gpio != HVM_GPIO_OFF;
    next_st.swk = !st.meas && st.wken && st.swsync[1];
    next_st.gwk = !st.meas && st.gwsync[1];
    next_st.lvu = !st.meas;
    next_st.lvv = st.meas ? st.lvv : st.lvsync[1];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.meas <= HVM_MEAS_RST;
      st.gpio <= HVM_GPIO_RST;
      st.pull <= HVM_PULL_RST;
      st.wake2 <= HVM_WAKE2_RST;
    end else begin
      st <= next_st;
    end
  end

  assign measure_path_enable = st.meas;
  assign measure_route_switch = st.sw;
  assign gpio_config = st.gpio;
  assign sense_pull_config = st.pull;
  assign wake_control_second = st.wake2;
  assign sense_wake_enable = st.wken;
  assign pull_active = st.pact;
  assign fail_out_active = st.fo;
  assign gpio_func_active = st.gact;
  assign sense_wake_set = st.swk;
  assign gpio_wake_set = st.gwk;
  assign level_update = st.lvu;
  assign level_value = st.lvv;
  assign spi_fault = st.fault;
  assign restart_req = st.rst;

  // ---------------------------------------------------
  // checks
  // ---------------------------------------------------
  sw_mode_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    st.sw |-> $past(mode) == HVM_MODE_NORMAL)
    else $error("switch closed outside normal mode");
  sw_follows_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st.meas && mode == HVM_MODE_NORMAL && !meas_wr) |=> st.sw)
    else $error("switch did not close");
  keep_cfg_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st.meas && mode != HVM_MODE_NORMAL && !meas_wr) |=> st.meas && !st.sw)
    else $error("config lost or switch closed");
  fs_open_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == HVM_MODE_FAILSAFE) |=> !st.sw)
    else $error("switch closed in fail-safe");
  pull_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    st.meas |-> st.pact == 2'h0)
    else $error("pull active while measuring");
  no_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
    st.meas |=> !st.swk && !st.gwk && !st.lvu)
    else $error("wake updated while measuring");
  sleep_fault_a: assert property (@(posedge clk) disable iff (!reset_n)
    (sleep_cmd && st.meas && !other_wake_src) |=> st.fault && st.rst)
    else $error("sleep conflict not flagged");
  refuse_a: assert property (@(posedge clk) disable iff (!reset_n)
    (meas_wr && meas_wdata && !st.meas && st.gpio != HVM_GPIO_OFF) |=> !st.meas && st.fault)
    else $error("enable not refused");
  gpio_fault_a: assert property (@(posedge clk) disable iff (!reset_n)
    (gpio_wr && st.meas && gpio_wdata != st.gpio) |=> st.fault)
    else $error("gpio change not flagged");
  fo_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    st.meas |-> !st.fo && !st.gact)
    else $error("fail output alive while measuring");
  // stored settings and gated pin paths
  reset_state_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> !st.meas && !st.sw && st.gpio == HVM_GPIO_RST)
    else $error("wrong state after reset");
  pull_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    pull_wr |=> st.pull == $past(pull_wdata))
    else $error("pull setting not stored");
  wake2_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    wake2_wr |=> st.wake2 == $past(wake2_wdata))
    else $error("second wake setting not stored");
  gpio_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    gpio_wr |=> st.gpio == $past(gpio_wdata))
    else $error("gpio setting not stored");
  wken_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    wake_en_wr |=> st.wken == $past(wake_en_wdata))
    else $error("wake enable not stored");
  wken_ignored_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st.meas && st.wken) |=> !st.swk)
    else $error("wake enable honoured while measuring");
  level_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    st.meas |=> st.lvv == $past(st.lvv))
    else $error("level status updated while measuring");
  sleep_ok_a: assert property (@(posedge clk) disable iff (!reset_n)
    (sleep_cmd && other_wake_src) |=> !st.rst)
    else $error("restart without sleep conflict");
endmodule

// File: hvm_pkg.sv
// Functional notes
// - after reset measurement is off, switch open, both pins keep ordinary functions
// - enable bit set closes switch only in normal mode, open otherwise
// - leaving normal mode opens switch but keeps the enable setting
// - with measurement on, pulls of both pins are off, inputs gated
// - pull, second wake and gpio settings ignored yet still stored
// - wake flags and level status not updated from the two pins
// - sleep with only pin wake sources sets spi fault, enters restart
// - fail output, its test drive, gpio and pin wake are unavailable
// - changing gpio configuration while measuring sets spi fault
// - enable write refused with spi fault unless shared pin is off
// - fail-safe entry keeps configuration but holds switch open
// - pin wake enables stay writable but are ignored while measuring
package hvm_pkg;
  localparam logic [2:0] HVM_MODE_NORMAL = 3'h0;
  localparam logic [2:0] HVM_MODE_STOP = 3'h1;
  localparam logic [2:0] HVM_MODE_SLEEP = 3'h2;
  localparam logic [2:0] HVM_MODE_RESTART = 3'h3;
  localparam logic [2:0] HVM_MODE_FAILSAFE = 3'h4;
  localparam logic [2:0] HVM_GPIO_OFF = 3'h4;
  localparam logic [2:0] HVM_GPIO_RST = 3'h4;
  localparam logic [1:0] HVM_PULL_RST = 2'h0;
  localparam logic [1:0] HVM_WAKE2_RST = 2'h0;
  localparam logic HVM_MEAS_RST = 1'h0;
endpackage

// File: hvm_adc_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// converter input behind the external divider
// ---------------------------------------------
module hvm_adc_model (
  // clock
  input wire logic clk,
  // divider node
  input wire logic route_closed,
  input wire logic node_level,
  // sampled code
  output logic adc_code = 1'b0
);
  // an open switch leaves the node floating, so the code toggles every cycle instead of holding the last level
  always @(posedge clk) begin
    if (route_closed) adc_code <= node_level;
    else adc_code <= ~adc_code;
  end
endmodule

// File: hv_measure_route_control_test.sv
`timescale 1ns/1ps
module hv_measure_route_control_test;
  import hvm_pkg::*;
  logic clk, reset_n, sleep_cmd, other_wake_src, meas_wr, meas_wdata, gpio_wr, pull_wr;
  logic wake2_wr, wake_en_wr, wake_en_wdata, fail_output_test_drive;
  logic sense_wake_evt, gpio_wake_evt, sense_level, measure_path_enable, measure_route_switch;
  logic fail_out_active, gpio_func_active, sense_wake_set, gpio_wake_set, level_update;
  logic level_value, spi_fault, restart_req, sense_wake_enable, adc;
  logic [2:0] mode, gpio_wdata, gpio_config;
  logic [1:0] pull_wdata, wake2_wdata, sense_pull_config, wake_control_second, pull_active;
  int mismatches = 0;
  int n_checks = 0;
  bit [31:0] lfsr = 32'haac9bde0;
  logic [1:0] exp_pull;
  // behavioural model of the stored settings and the fault pulse
  int m_meas = 0;
  int m_gpio = HVM_GPIO_RST;
  int m_pull = 0;
  int m_wake2 = 0;
  int m_wken = 0;
  int m_fault = 0;
  hvm_route_ctrl hvm_route_ctrl_inst (.clk, .reset_n, .mode, .sleep_cmd, .other_wake_src,
    .meas_wr, .meas_wdata, .gpio_wr, .gpio_wdata, .pull_wr, .pull_wdata, .wake2_wr,
    .wake2_wdata, .wake_en_wr, .wake_en_wdata, .fail_output_test_drive, .sense_wake_evt,
    .gpio_wake_evt, .sense_level, .measure_path_enable, .measure_route_switch, .gpio_config,
    .sense_pull_config, .wake_control_second, .sense_wake_enable, .pull_active,
    .fail_out_active, .gpio_func_active, .sense_wake_set, .gpio_wake_set, .level_update,
    .level_value, .spi_fault, .restart_req);
  hvm_adc_model hvm_adc_model_inst (.clk, .route_closed(measure_route_switch),
    .node_level(sense_level), .adc_code(adc));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic bit [31:0] nxt(bit [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(logic [3:0] seen, logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // k selects the strobe: 0 meas, 1 gpio, 2 pull, 3 wake enable, 4 second wake
  task automatic wr(int k, logic [2:0] v);
    @(posedge clk);
    {meas_wdata, gpio_wdata, pull_wdata, wake2_wdata, wake_en_wdata} <= {v[0], v, v[1:0], v[1:0], v[0]};
    {meas_wr, gpio_wr, pull_wr, wake_en_wr, wake2_wr} <= 5'h10 >> k;
    m_fault = 0;
    if (k == 0 && v[0] && m_gpio != HVM_GPIO_OFF) m_fault = 1;
    else if (k == 0) m_meas = v[0];
    if (k == 1 && m_meas != 0 && v != m_gpio) m_fault = 1;
    if (k == 1) m_gpio = v;
    if (k == 2) m_pull = v[1:0];
    if (k == 3) m_wken = v[0];
    if (k == 4) m_wake2 = v[1:0];
    @(posedge clk);
    {meas_wr, gpio_wr, pull_wr, wake_en_wr, wake2_wr} <= 5'h0;
    #1;
    chk(measure_path_enable, m_meas);
    chk(gpio_config, m_gpio);
    chk(spi_fault, m_fault);
    chk(sense_pull_config, m_pull);
    chk(wake_control_second, m_wake2);
    chk(sense_wake_enable, m_wken);
    chk(pull_active, m_meas != 0 ? 0 : m_pull);
    chk(measure_route_switch, m_meas != 0 && mode == HVM_MODE_NORMAL);
  endtask
  task automatic sleep_try(logic other, logic exp);
    @(posedge clk);
    {other_wake_src, sleep_cmd} <= {other, 1'b1};
    @(posedge clk);
    sleep_cmd <= 1'b0;
    #1;
    chk(spi_fault, exp);
    chk(restart_req, exp);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ---------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    mismatches++;
    close_out();
  end
  initial begin
    {mode, sleep_cmd, other_wake_src, meas_wr, meas_wdata, gpio_wr, gpio_wdata} = '0;
    {pull_wr, pull_wdata, wake2_wr, wake2_wdata, wake_en_wr, wake_en_wdata} = '0;
    {fail_output_test_drive, sense_wake_evt, gpio_wake_evt, sense_level} = '0;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    {fail_output_test_drive, sense_wake_evt, gpio_wake_evt, sense_level} <= 4'hf;
    tick(4);
    chk(measure_path_enable, 0);
    chk(measure_route_switch, 0);
    chk(gpio_config, HVM_GPIO_RST);
    chk(sense_wake_set, 0);
    chk(gpio_wake_set, 1);
    chk({level_update, level_value}, 2'h3);
    chk(fail_out_active, 1);
    @(posedge clk);
    {fail_output_test_drive, sense_wake_evt, gpio_wake_evt, sense_level} <= 4'h0;
    wr(1, 3'h1);
    chk(gpio_func_active, 1);
    wr(0, 3'h1);
    chk(spi_fault, 1);
    chk(measure_path_enable, 0);
    wr(1, HVM_GPIO_OFF);
    wr(0, 3'h1);
    chk(spi_fault, 0);
    chk(measure_route_switch, 1);
    wr(1, 3'h2);
    chk(spi_fault, 1);
    chk(gpio_config, 3'h2);
    wr(1, HVM_GPIO_OFF);
    repeat (4) begin
      lfsr = nxt(lfsr);
      exp_pull = lfsr[1:0];
      wr(2, lfsr[2:0]);
      chk(sense_pull_config, exp_pull);
      chk(pull_active, 0);
      wr(4, lfsr[4:2]);
      chk(wake_control_second, lfsr[3:2]);
      wr(3, lfsr[7:5]);
      chk(sense_wake_enable, lfsr[5]);
    end
    @(posedge clk);
    {fail_output_test_drive, sense_wake_evt, gpio_wake_evt, sense_level} <= 4'hf;
    tick(5);
    chk({sense_wake_set, gpio_wake_set, level_update}, 0);
    chk(level_value, 0);
    chk({fail_out_active, gpio_func_active}, 0);
    chk(adc, 1);
    sleep_try(1'b0, 1'b1);
    sleep_try(1'b1, 1'b0);
    for (int m = 1; m <= 5; m++) begin
      @(posedge clk);
      mode <= 3'(m % 5);
      tick(1);
      chk(measure_route_switch, m == 5);
      chk(measure_path_enable, 1);
    end
    wr(0, 3'h0);
    chk(measure_route_switch, 0);
    chk(pull_active, exp_pull);
    close_out();
  end
endmodule
